// *** char_rotator.sv ***
// six-bit character extraction and word rotation
module char_rotator
  import convert_pkg::*;
(
  input wire logic [WORD_W-1:0] i_word,
  input wire logic i_scan_right,
  input wire logic [CHAR_W-1:0] i_new_char,
  output logic [CHAR_W-1:0] o_char,
  output logic [WORD_W-1:0] o_rotated
);
  // left scan takes the high character and rotates left, the replacement
  // landing at the low end; right scan is the mirror image
  always_comb begin
    if (i_scan_right) begin
      o_char = i_word[CHAR_W-1:0];
      o_rotated = {i_new_char, i_word[WORD_W-1:CHAR_W]};
    end else begin
      o_char = i_word[WORD_W-1:CHAR_HI_LSB];
      o_rotated = {i_word[CHAR_HI_LSB-1:0], i_new_char};
    end
  end
endmodule : char_rotator

// *** convert_pkg.sv ***
// shared constants and types for the table lookup convert unit
package convert_pkg;
  localparam int WORD_W = 36;
  localparam int ADDR_W = 15;
  localparam int CHAR_W = 6;
  localparam int COUNT_W = 8;
  localparam int NUM_CHARS = 6;
  // address part occupies bits 21..35 (msb-first numbering) = low 15 bits
  localparam int ADDR_LSB = 0;
  // S,1-5 field = top six bits
  localparam int CHAR_HI_LSB = WORD_W - CHAR_W;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 15'h0000;
  localparam logic [WORD_W-1:0] WORD_ZERO = 36'h0_0000_0000;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 8'h01;
  localparam logic [1:0] TAG_XR1 = 2'h1;
  localparam logic [1:0] OP_MQ_REPLACE = 2'h0;
  localparam logic [1:0] OP_ACC_REPLACE = 2'h1;
  localparam logic [1:0] OP_ACC_ADD = 2'h2;
  typedef enum logic [1:0] {
    mq_replace_convert,
    acc_replace_convert,
    acc_add_lookup_convert,
    op_none
  } convert_op_t;
  typedef enum {
    st_idle,
    st_fetch,
    st_wait,
    st_apply,
    st_done
  } convert_state_t;
endpackage : convert_pkg

// *** convert_unit.sv ***
// table lookup convert unit: sequencer and datapath for three convert operations
//
// Overview of operation
// - mq replace first fetch base plus high char
// - fetched S,1-5 replaces scanned character
// - later addresses use previous address part
// - count decrements per character, ends at zero
// - tag one loads index register 1
// - accumulator replace scans low end first
// - next char added to previous address part
// - accumulator char overwritten with fetched field
// - tag one copies last address to xr1
// - add lookup sums fetched words into accumulator
// - add lookup scans mq high char first
// - operand treated as six six-bit characters
module table_lookup_convert_unit
  import convert_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_start,
  input wire logic [1:0] i_op,
  input wire logic [ADDR_W-1:0] i_base_addr,
  input wire logic [1:0] i_tag,
  input wire logic [COUNT_W-1:0] i_count,
  input wire logic [WORD_W-1:0] i_mq_load,
  input wire logic i_mq_load_en,
  input wire logic [WORD_W-1:0] i_acc_load,
  input wire logic i_acc_load_en,
  input wire logic i_mem_ready,
  input wire logic [WORD_W-1:0] i_mem_rdata,
  output logic o_mem_req,
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic o_busy,
  output logic o_done,
  output logic [WORD_W-1:0] o_multiplier_quotient_reg,
  output logic [WORD_W-1:0] o_accumulator,
  output logic [WORD_W-1:0] o_fetched_word_reg,
  output logic [ADDR_W-1:0] o_index_reg1,
  output logic o_index_reg1_load,
  output logic [COUNT_W-1:0] o_count
);
  ////////////////////////////////////////////////////////////////////////
  logic rst_n;

  reset_sync u_reset_sync (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .o_rst_n(rst_n)
  );

  ////////////////////////////////////////////////////////////////////////
  convert_state_t state_r, state_nxt;
  convert_op_t op_r, op_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [ADDR_W-1:0] chain_r, chain_nxt;
  logic [COUNT_W-1:0] count_r, count_nxt;
  logic [1:0] tag_r, tag_nxt;
  logic [WORD_W-1:0] mq_r, mq_nxt;
  logic [WORD_W-1:0] acc_r, acc_nxt;
  logic [WORD_W-1:0] sr_r, sr_nxt;
  logic [ADDR_W-1:0] xr1_r, xr1_nxt;
  logic xr1_load_r, xr1_load_nxt;
  logic done_r, done_nxt;
  logic req_r, req_nxt;

  function automatic convert_op_t decode_op(input logic [1:0] code);
    case (code)
      OP_MQ_REPLACE: decode_op = mq_replace_convert;
      OP_ACC_REPLACE: decode_op = acc_replace_convert;
      OP_ACC_ADD: decode_op = acc_add_lookup_convert;
      default: decode_op = op_none;
    endcase
  endfunction : decode_op

  function automatic logic [ADDR_W-1:0] char_addr(input logic [ADDR_W-1:0] base,
                                                  input logic [CHAR_W-1:0] ch);
    char_addr = base + {{(ADDR_W-CHAR_W){1'b0}}, ch};
  endfunction : char_addr

  ////////////////////////////////////////////////////////////////////////
  // the operand in use is the accumulator only for accumulator replace
  logic scan_right;
  logic [WORD_W-1:0] operand;
  logic [CHAR_W-1:0] cur_char;
  logic [WORD_W-1:0] rotated;
  logic [CHAR_W-1:0] new_char;

  always_comb begin
    scan_right = (op_r == acc_replace_convert);
    operand = scan_right ? acc_r : mq_r;
  end

  // add lookup consumes its character but keeps it, so mq returns intact
  // after six rotations; kept apart so the character path never loops back
  always_comb begin
    if (op_r == acc_add_lookup_convert) begin
      new_char = cur_char;
    end else begin
      new_char = i_mem_rdata[WORD_W-1:CHAR_HI_LSB];
    end
  end

  char_rotator u_char_rotator (
    .i_word(operand),
    .i_scan_right(scan_right),
    .i_new_char(new_char),
    .o_char(cur_char),
    .o_rotated(rotated)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    chain_nxt = chain_r;
    count_nxt = count_r;
    tag_nxt = tag_r;
    mq_nxt = mq_r;
    acc_nxt = acc_r;
    sr_nxt = sr_r;
    xr1_nxt = xr1_r;
    xr1_load_nxt = 1'b0;
    done_nxt = 1'b0;
    req_nxt = 1'b0;
    case (state_r)
      st_idle: begin
        if (i_mq_load_en) begin
          mq_nxt = i_mq_load;
        end
        if (i_acc_load_en) begin
          acc_nxt = i_acc_load;
        end
        if (i_start) begin
          op_nxt = decode_op(i_op);
          chain_nxt = i_base_addr;
          count_nxt = i_count;
          tag_nxt = i_tag;
          if (decode_op(i_op) == op_none) begin
            done_nxt = 1'b1;
          end else if (i_count == COUNT_ZERO) begin
            state_nxt = st_done;
          end else begin
            state_nxt = st_fetch;
          end
        end
      end
      st_fetch: begin
        // first cycle uses the base, later ones the chained address part
        addr_nxt = char_addr(chain_r, cur_char);
        req_nxt = 1'b1;
        state_nxt = st_wait;
      end
      st_wait: begin
        req_nxt = 1'b1;
        if (i_mem_ready) begin
          req_nxt = 1'b0;
          sr_nxt = i_mem_rdata;
          chain_nxt = i_mem_rdata[ADDR_LSB +: ADDR_W];
          if (scan_right) begin
            acc_nxt = rotated;
          end else begin
            mq_nxt = rotated;
          end
          if (op_r == acc_add_lookup_convert) begin
            // low address parts also sum here; tables must avoid carry-out
            acc_nxt = acc_r + i_mem_rdata;
          end
          count_nxt = count_r - COUNT_ONE;
          state_nxt = st_apply;
        end
      end
      st_apply: begin
        if (count_r == COUNT_ZERO) begin
          state_nxt = st_done;
        end else begin
          state_nxt = st_fetch;
        end
      end
      st_done: begin
        if (tag_r == TAG_XR1) begin
          xr1_nxt = sr_r[ADDR_LSB +: ADDR_W];
          xr1_load_nxt = 1'b1;
        end
        done_nxt = 1'b1;
        state_nxt = st_idle;
      end
      default: begin
        state_nxt = st_idle;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= st_idle;
      op_r <= op_none;
      addr_r <= ADDR_ZERO;
      chain_r <= ADDR_ZERO;
      count_r <= COUNT_ZERO;
      tag_r <= 2'h0;
      mq_r <= WORD_ZERO;
      acc_r <= WORD_ZERO;
      sr_r <= WORD_ZERO;
      xr1_r <= ADDR_ZERO;
      xr1_load_r <= 1'b0;
      done_r <= 1'b0;
      req_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      chain_r <= chain_nxt;
      count_r <= count_nxt;
      tag_r <= tag_nxt;
      mq_r <= mq_nxt;
      acc_r <= acc_nxt;
      sr_r <= sr_nxt;
      xr1_r <= xr1_nxt;
      xr1_load_r <= xr1_load_nxt;
      done_r <= done_nxt;
      req_r <= req_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign o_mem_req = req_r;
  assign o_mem_addr = addr_r;
  assign o_busy = (state_r != st_idle);
  assign o_done = done_r;
  assign o_multiplier_quotient_reg = mq_r;
  assign o_accumulator = acc_r;
  assign o_fetched_word_reg = sr_r;
  assign o_index_reg1 = xr1_r;
  assign o_index_reg1_load = xr1_load_r;
  assign o_count = count_r;
endmodule : table_lookup_convert_unit

// *** convert_unit_chk_sva.sv ***
// port-level assertions for the table lookup convert unit
module convert_unit_chk
  import convert_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_start,
  input wire logic [1:0] i_op,
  input wire logic [ADDR_W-1:0] i_base_addr,
  input wire logic [1:0] i_tag,
  input wire logic [COUNT_W-1:0] i_count,
  input wire logic i_mem_ready,
  input wire logic [WORD_W-1:0] i_mem_rdata,
  input wire logic o_mem_req,
  input wire logic [ADDR_W-1:0] o_mem_addr,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic [WORD_W-1:0] o_multiplier_quotient_reg,
  input wire logic [WORD_W-1:0] o_accumulator,
  input wire logic [WORD_W-1:0] o_fetched_word_reg,
  input wire logic [ADDR_W-1:0] o_index_reg1,
  input wire logic o_index_reg1_load,
  input wire logic [COUNT_W-1:0] o_count
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  ////////////////////////////////////////
  sequence take_left;
    i_start && !o_busy && !i_op[0] && i_count != COUNT_ZERO;
  endsequence
  sequence got;
    o_mem_req && i_mem_ready;
  endsequence
  sequence take_right;
    i_start && !o_busy && i_op == OP_ACC_REPLACE && i_count != COUNT_ZERO;
  endsequence
  sequence waiting;
    o_mem_req && !i_mem_ready;
  endsequence
  a_right_first: assert property (
    take_right |-> ##2 o_mem_req && o_mem_addr == i_base_addr + o_accumulator[5:0])
    else $error("bad first right scan address");
  // a fetch must not move or drop before core storage answers
  a_fetch_hold: assert property (
    waiting |=> o_mem_req && $stable(o_mem_addr))
    else $error("fetch request not held");
  a_left_first: assert property (
    take_left |-> ##2 o_mem_req && o_mem_addr == i_base_addr + o_multiplier_quotient_reg[35:30])
    else $error("bad first address");
  // skipping two edges back excludes the first fetch, which uses the base
  a_chain_addr: assert property (
    $rose(o_mem_req) && $past(o_busy, 2) |-> o_mem_addr == o_fetched_word_reg[14:0] +
    (i_op == OP_ACC_REPLACE ? o_accumulator[5:0] : o_multiplier_quotient_reg[35:30]))
    else $error("bad chained address");
  a_count_step: assert property (
    got |=> o_count == $past(o_count) - COUNT_ONE)
    else $error("count not stepped");
  a_done_bound: assert property (
    got ##0 (o_count == COUNT_ONE) |-> ##[1:3] o_done)
    else $error("no done after last char");
  a_mq_rotate: assert property (
    got ##0 (i_op == OP_MQ_REPLACE) |=> o_multiplier_quotient_reg ==
    {$past(o_multiplier_quotient_reg[29:0]), $past(i_mem_rdata[35:30])})
    else $error("bad mq replace");
  a_acc_rotate: assert property (
    got ##0 (i_op == OP_ACC_REPLACE) |=> o_accumulator ==
    {$past(i_mem_rdata[35:30]), $past(o_accumulator[35:6])})
    else $error("bad acc replace");
  a_add_sum: assert property (
    got ##0 (i_op == OP_ACC_ADD) |=> o_accumulator == $past(o_accumulator) + $past(i_mem_rdata))
    else $error("bad add lookup sum");
  a_xr1_load: assert property (
    o_done && i_tag == TAG_XR1 && i_op != 2'h3 |->
    o_index_reg1_load && o_index_reg1 == o_fetched_word_reg[14:0])
    else $error("index register not loaded");
endmodule : convert_unit_chk
bind table_lookup_convert_unit convert_unit_chk u_chk (
  .i_clk(i_clk),
  .i_arst_n(i_arst_n),
  .i_start(i_start),
  .i_op(i_op),
  .i_base_addr(i_base_addr),
  .i_tag(i_tag),
  .i_count(i_count),
  .i_mem_ready(i_mem_ready),
  .i_mem_rdata(i_mem_rdata),
  .o_mem_req(o_mem_req),
  .o_mem_addr(o_mem_addr),
  .o_busy(o_busy),
  .o_done(o_done),
  .o_multiplier_quotient_reg(o_multiplier_quotient_reg),
  .o_accumulator(o_accumulator),
  .o_fetched_word_reg(o_fetched_word_reg),
  .o_index_reg1(o_index_reg1),
  .o_index_reg1_load(o_index_reg1_load),
  .o_count(o_count)
);

// *** reset_sync.sv ***
// two-flop release of the asynchronous reset
module reset_sync (
  input wire logic i_clk,
  input wire logic i_arst_n,
  output logic o_rst_n
);
  logic [1:0] sync_r;
  logic [1:0] sync_nxt;

  always_comb begin
    sync_nxt = {sync_r[0], 1'b1};
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync_r <= 2'h0;
    end else begin
      sync_r <= sync_nxt;
    end
  end

  assign o_rst_n = sync_r[1];
endmodule : reset_sync

// *** table_lookup_convert_unit_tb_top.sv ***
// self-checking bench for the table lookup convert unit
module table_lookup_convert_unit_tb_top
  import convert_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk, o_mem_req, o_busy, o_done, o_index_reg1_load, i_mem_ready;
  logic i_arst_n = 1'b0, i_start = 1'b0, i_mq_load_en = 1'b0, i_acc_load_en = 1'b0;
  logic [1:0] i_op = 2'h0, i_tag = 2'h0, lat = 2'h0;
  logic [ADDR_W-1:0] i_base_addr = 15'h0000, o_mem_addr, o_index_reg1, xr = 15'h0000;
  logic [COUNT_W-1:0] i_count = 8'h00, o_count;
  logic [WORD_W-1:0] i_mq_load = WORD_ZERO, i_acc_load = WORD_ZERO, sr = WORD_ZERO;
  logic [WORD_W-1:0] i_mem_rdata, o_multiplier_quotient_reg, o_accumulator, o_fetched_word_reg;
  logic [WORD_W-1:0] exp_q[$];
  logic [15:0] seed = 16'hCD58;
  int failures = 0;
  int n_checks = 0;
  logic hung = 1'b0;
  table_lookup_convert_unit dut (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_start(i_start),
    .i_op(i_op),
    .i_base_addr(i_base_addr),
    .i_tag(i_tag),
    .i_count(i_count),
    .i_mq_load(i_mq_load),
    .i_mq_load_en(i_mq_load_en),
    .i_acc_load(i_acc_load),
    .i_acc_load_en(i_acc_load_en),
    .i_mem_ready(i_mem_ready),
    .i_mem_rdata(i_mem_rdata),
    .o_mem_req(o_mem_req),
    .o_mem_addr(o_mem_addr),
    .o_busy(o_busy),
    .o_done(o_done),
    .o_multiplier_quotient_reg(o_multiplier_quotient_reg),
    .o_accumulator(o_accumulator),
    .o_fetched_word_reg(o_fetched_word_reg),
    .o_index_reg1(o_index_reg1),
    .o_index_reg1_load(o_index_reg1_load),
    .o_count(o_count)
  );
  table_memory_model mem (.i_clk(i_clk), .i_req(o_mem_req), .i_addr(o_mem_addr),
    .i_lat(lat), .o_ready(i_mem_ready), .o_rdata(i_mem_rdata));
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  ////////////////////////////////////////
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction : rnd
  task automatic chk(input string nm, input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic run(input int t, input logic [1:0] op, input logic [7:0] cnt);
    logic [WORD_W-1:0] q, a, w;
    logic [ADDR_W-1:0] p;
    logic [1:0] tg;
    logic [5:0] c;
    int k;
    q = 36'({rnd(), rnd(), rnd()});
    a = 36'({rnd(), rnd(), rnd()});
    p = 15'(rnd());
    tg = (op == 2'h3) ? 2'h0 : 2'(rnd()) & 2'h1;
    @(posedge i_clk);
    i_mq_load <= q;
    i_acc_load <= a;
    i_mq_load_en <= 1'b1;
    i_acc_load_en <= 1'b1;
    lat <= 2'(rnd());
    @(posedge i_clk);
    i_mq_load_en <= 1'b0;
    i_acc_load_en <= 1'b0;
    i_start <= 1'b1;
    i_op <= op;
    i_tag <= tg;
    i_count <= cnt;
    i_base_addr <= p;
    for (k = 0; k < cnt && op != 2'h3; k++) begin
      c = (op == OP_ACC_REPLACE) ? a[5:0] : q[35:30];
      w = mem.tbl(p + 15'(c));
      sr = w;
      p = w[14:0];
      if (op == OP_MQ_REPLACE) q = {q[29:0], w[35:30]};
      if (op == OP_ACC_REPLACE) a = {w[35:30], a[35:6]};
      if (op == OP_ACC_ADD) a = a + w;
      if (op == OP_ACC_ADD) q = {q[29:0], c};
    end
    if (tg == 2'h1) xr = sr[14:0];
    exp_q.push_back(q);
    exp_q.push_back(a);
    exp_q.push_back({20'h00000, tg == 2'h1, xr});
    exp_q.push_back(sr);
    @(posedge i_clk);
    i_start <= 1'b0;
    k = 0;
    do begin
      @(negedge i_clk);
      k++;
    end while (o_done !== 1'b1 && k < 300);
    // a hang is counted here and stops the scenario loop before the report
    if (o_done !== 1'b1) begin
      failures++;
      hung = 1'b1;
    end
    $display("test %0d op %0d count %0d done", t, op, cnt);
  endtask : run
  always @(negedge i_clk) begin
    if (o_done === 1'b1) begin
      chk("mq", exp_q.pop_front(), o_multiplier_quotient_reg);
      chk("acc", exp_q.pop_front(), o_accumulator);
      chk("xr1", exp_q.pop_front(), {20'h00000, o_index_reg1_load, o_index_reg1});
      chk("sr", exp_q.pop_front(), o_fetched_word_reg);
    end
  end
  initial begin
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    for (int t = 0; t < 16 && !hung; t++) begin
      run(t, 2'(t), t < 4 ? 8'h06 : 8'(t % 9));
    end
    tally_and_finish();
  end
endmodule : table_lookup_convert_unit_tb_top

// *** table_memory_model.sv ***
// core storage model answering table fetches after a chosen wait
module table_memory_model
  import convert_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [1:0] i_lat,
  output logic o_ready,
  output logic [WORD_W-1:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] n = 2'h0;
  initial o_ready = 1'b0;
  initial o_rdata = WORD_ZERO;
  // link parts stay tiny so summed links never reach the binary field
  function automatic logic [WORD_W-1:0] tbl(input logic [ADDR_W-1:0] a);
    return {a[5:0] ^ 6'h2D, a ^ 15'h5A5A, 9'h000, a[5:0] + 6'h11};
  endfunction : tbl
  ////////////////////////////////////////
  // data toggles off the ready cycle so stale words never look valid
  always @(posedge i_clk) begin
    o_ready <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_req && !o_ready) begin
      n <= n + 2'h1;
      if (n == i_lat) begin
        o_ready <= 1'b1;
        o_rdata <= tbl(i_addr);
        n <= 2'h0;
      end
    end
  end
endmodule : table_memory_model
